// ==== core/qls_pkg.sv ====
// constants shared by the quad-channel receive striper and its fifo
// assumes a single 20 MHz system clock drives every consumer
package qls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry of the striped link
  localparam int NUM_CHAN = 4;
  localparam int LANES_PER_CHAN = 4;
  localparam int NUM_LANES = NUM_CHAN * LANES_PER_CHAN;
  localparam int BYTE_BITS = 8;
  localparam int GROUP_BITS = LANES_PER_CHAN * BYTE_BITS;
  localparam int SAMPLE_BITS = 64;
  localparam int CHAN_SAMPLE_BITS = LANES_PER_CHAN * SAMPLE_BITS;
  localparam int FIFO_DEPTH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // deskew reference frame: 4 framing bytes, 4 header bytes, 32 sample bytes
  localparam logic [5:0] HDR_GROUPS = 6'h08;
  localparam logic [5:0] FRAME_LAST = 6'h27;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // framing pattern value is arbitrary
  localparam logic [31:0] FRAME_WORD = 32'ha5c3_5a3c;
  localparam logic [31:0] HDR_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_TIME_NS = 200;
  localparam int BIT_DIV = (BIT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                           BIT_TIME_NS / CLK_PERIOD_NS;

endpackage : qls_pkg

// ==== core/qls_stream_if.sv ====
// valid/ready carrier between the striper and its group fifo
// assumes both ends share one clock
`timescale 1ns/1ns
interface qls_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : qls_stream_if

// ==== core/qls_fifo.sv ====
// group fifo: width and depth are parameters, registered flags
// assumes depth is a power of two so pointers wrap by themselves
`timescale 1ns/1ns
module qls_fifo import qls_pkg::*; #(
  parameter int W = 128,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // streams
  qls_stream_if.sink fill,
  qls_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic not_full_q;
  logic not_empty_q;
  logic push;
  logic pop;

  assign push = fill.valid && not_full_q;
  assign pop = drain.ready && not_empty_q;
  assign fill.ready = not_full_q;
  assign drain.valid = not_empty_q;
  assign drain.data = mem_q[rd_ptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (!push && pop) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      not_full_q <= 1'b1;
      not_empty_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      cnt_q <= cnt_d;
      not_full_q <= (cnt_d != CW'(DEPTH));
      not_empty_q <= (cnt_d != '0);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_fifo_full_flag: assert property (
    (cnt_q == CW'(DEPTH)) |-> !not_full_q)
    else $error("fifo full but still ready");
  a_fifo_no_underflow: assert property (
    (cnt_q == '0) |-> !not_empty_q)
    else $error("fifo empty but still valid");

endmodule : qls_fifo

// ==== core/qls_rx_striper.sv ====
// quad-channel receive striper with per-channel deskew reference streams
// assumes inputs other than the reference synchronous to clk; lanes serial, one bit per bit tick
`timescale 1ns/1ns
module qls_rx_striper import qls_pkg::*; #(
  parameter int BIT_DIV_CYC = BIT_DIV,
  parameter logic [31:0] FRAME_PATTERN = FRAME_WORD
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // recovered stripe groups, channel n in bits 32n-1..32n-32
  input wire logic [NUM_CHAN*GROUP_BITS-1:0] group_data,
  input wire logic group_valid,
  output logic group_ready,
  // control
  input wire logic [NUM_CHAN-1:0] chan_signal_ok,
  input wire logic single_chan_mode,
  input wire logic ref_select,
  input wire logic inbound_frequency_reference,
  // striped lanes
  output logic [NUM_LANES-1:0] inbound_lanes,
  // forwarded data clocks
  output logic chan1_forwarded_clock,
  output logic chan2_forwarded_clock,
  output logic chan3_forwarded_clock,
  output logic chan4_forwarded_clock,
  // deskew reference streams
  output logic chan1_skew_reference,
  output logic chan2_skew_reference,
  output logic chan3_skew_reference,
  output logic chan4_skew_reference,
  // status lines
  output logic chan1_alarm_line,
  output logic chan2_alarm_line,
  output logic chan3_alarm_line,
  output logic chan4_alarm_line
);
  localparam int DW = NUM_CHAN * GROUP_BITS;
  localparam logic [63:0] HDR_BITS = {FRAME_PATTERN, HDR_WORD};

  ////////////////////////////////////////////////////////////////////////////
  // group fifo
  qls_stream_if #(.W(DW)) in_if ();
  qls_stream_if #(.W(DW)) out_if ();

  assign in_if.valid = group_valid;
  assign in_if.data = group_data;
  assign group_ready = in_if.ready;

  qls_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .fill(in_if.sink),
    .drain(out_if.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit tick: internal divider or reference clock edges
  logic [7:0] div_q;
  logic div_tick;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic ref_edge;
  logic ref_pend_q;
  logic tick;

  assign div_tick = (div_q == 8'(BIT_DIV_CYC - 1));
  assign ref_edge = ref_s2_q ^ ref_s3_q;
  // a reference half period spans two bit times: two ticks per edge
  assign tick = ref_select ? (ref_edge | ref_pend_q) : div_tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 8'h00;
    end else if (div_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // reference input is free-running, so it gets a full synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      ref_pend_q <= 1'b0;
    end else begin
      ref_s1_q <= inbound_frequency_reference;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      ref_pend_q <= ref_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte and frame position, shared by all channels
  logic [2:0] bit_idx_q;
  logic [5:0] grp_q;
  logic [5:0] grp_d;
  logic load;
  logic capture;
  logic starving_q;

  assign load = tick && (bit_idx_q == BYTE_LAST);
  assign out_if.ready = load;
  assign grp_d = (grp_q == FRAME_LAST) ? 6'h00 : grp_q + 6'h01;
  assign capture = load && (grp_d < HDR_GROUPS);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_idx_q <= 3'h0;
      grp_q <= 6'h00;
    end else if (tick) begin
      bit_idx_q <= bit_idx_q + 3'h1;
      if (load) begin
        grp_q <= grp_d;
      end
    end
  end

  // an empty fifo at a group boundary means filler, not optical data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      starving_q <= 1'b1;
    end else if (load) begin
      starving_q <= !out_if.valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel striping, deskew and status
  logic [GROUP_BITS-1:0] shift_q [NUM_CHAN];
  logic [CHAN_SAMPLE_BITS-1:0] samp_q [NUM_CHAN];
  logic [NUM_LANES-1:0] lane_q;
  logic [NUM_CHAN-1:0] fwd_clk_q;
  logic [NUM_CHAN-1:0] skew_q;
  logic [NUM_CHAN-1:0] alarm_q;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic [GROUP_BITS-1:0] word;
    logic quiet;
    logic hdr_bit;
    logic [LANES_PER_CHAN-1:0] lane_c_q;

    assign word = out_if.valid ? out_if.data[c*GROUP_BITS +: GROUP_BITS]
                               : '0;
    // only channel 1 runs its clock and deskew in single mode
    assign quiet = single_chan_mode && (c != 0);
    assign hdr_bit = HDR_BITS[6'h3f - {grp_q[2:0], bit_idx_q}];
    // one process per channel slice keeps a single driver per lane bit
    assign lane_q[c*LANES_PER_CHAN +: LANES_PER_CHAN] = lane_c_q;

    // lane 4c+j takes byte j; group bit 1 sits in the msb
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        shift_q[c] <= '0;
        lane_c_q <= '0;
      end else if (tick) begin
        for (int j = 0; j < LANES_PER_CHAN; j++) begin
          lane_c_q[j] <= shift_q[c][j*BYTE_BITS + 7];
        end
        if (load) begin
          shift_q[c] <= word;
        end else begin
          for (int j = 0; j < LANES_PER_CHAN; j++) begin
            shift_q[c][j*BYTE_BITS +: BYTE_BITS] <=
              {shift_q[c][j*BYTE_BITS +: 7], 1'b0};
          end
        end
      end
    end

    // samples fill during the header groups, drain during the rest
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        samp_q[c] <= '0;
      end else if (capture) begin
        for (int j = 0; j < LANES_PER_CHAN; j++) begin
          samp_q[c][j*SAMPLE_BITS +: SAMPLE_BITS] <=
            {samp_q[c][j*SAMPLE_BITS +: 56],
             word[j*BYTE_BITS +: BYTE_BITS]};
        end
      end else if (tick && (grp_q >= HDR_GROUPS)) begin
        // lane 3 sample occupies the top, so it leaves first
        samp_q[c] <= {samp_q[c][CHAN_SAMPLE_BITS-2:0], 1'b0};
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        skew_q[c] <= 1'b0;
      end else if (quiet) begin
        skew_q[c] <= 1'b0;
      end else if (tick) begin
        skew_q[c] <= (grp_q < HDR_GROUPS) ? hdr_bit
                                          : samp_q[c][CHAN_SAMPLE_BITS-1];
      end
    end

    // toggles every second bit tick: quarter bit rate, even duty
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        fwd_clk_q[c] <= 1'b0;
      end else if (quiet) begin
        fwd_clk_q[c] <= 1'b0;
      end else if (tick && bit_idx_q[0]) begin
        fwd_clk_q[c] <= ~fwd_clk_q[c];
      end
    end

    // alarm is a level; downstream must resynchronise it
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        alarm_q[c] <= 1'b1;
      end else begin
        alarm_q[c] <= !chan_signal_ok[c] || starving_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign inbound_lanes = lane_q;
  assign chan1_forwarded_clock = fwd_clk_q[0];
  assign chan2_forwarded_clock = fwd_clk_q[1];
  assign chan3_forwarded_clock = fwd_clk_q[2];
  assign chan4_forwarded_clock = fwd_clk_q[3];
  assign chan1_skew_reference = skew_q[0];
  assign chan2_skew_reference = skew_q[1];
  assign chan3_skew_reference = skew_q[2];
  assign chan4_skew_reference = skew_q[3];
  assign chan1_alarm_line = alarm_q[0];
  assign chan2_alarm_line = alarm_q[1];
  assign chan3_alarm_line = alarm_q[2];
  assign chan4_alarm_line = alarm_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_alarm_on_loss: assert property (
    !chan_signal_ok[2] |=> chan3_alarm_line)
    else $error("alarm not raised on signal loss");

  a_alarm_idle_ok: assert property (
    (chan_signal_ok == 4'hf && !starving_q) |=> !chan1_alarm_line &&
      !chan4_alarm_line)
    else $error("alarm raised while data is valid");

  a_group_load_word: assert property (
    (load && out_if.valid) |=>
      shift_q[1] == $past(out_if.data[GROUP_BITS +: GROUP_BITS]))
    else $error("group not loaded into channel 2");

  a_lane_high_msb: assert property (
    (tick && !load) |=> inbound_lanes[7] == $past(shift_q[1][31]) ##0
      shift_q[1][31:25] == $past(shift_q[1][30:24]))
    else $error("lane 7 bit order broken");

  a_clock_toggle: assert property (
    (tick && bit_idx_q[0] && !single_chan_mode) |=>
      chan2_forwarded_clock != $past(chan2_forwarded_clock))
    else $error("forwarded clock missed a toggle");

  a_clock_hold: assert property (
    (!(tick && bit_idx_q[0])) |=> $stable(chan1_forwarded_clock))
    else $error("forwarded clock moved between toggles");

  a_single_quiet: assert property (
    single_chan_mode |=> !chan2_forwarded_clock && !chan4_skew_reference)
    else $error("idle channel active in single mode");

  a_frame_first_bit: assert property (
    (tick && grp_q == 6'h00 && bit_idx_q == 3'h0) |=>
      chan1_skew_reference == FRAME_PATTERN[31])
    else $error("frame does not open with the framing msb");

  a_frame_wrap: assert property (
    (load && grp_q == FRAME_LAST) |=> grp_q == 6'h00 && capture == 1'b0)
    else $error("frame length wrong");

  a_sample_lead: assert property (
    (tick && grp_q == HDR_GROUPS && bit_idx_q == 3'h0) |=>
      chan1_skew_reference == $past(samp_q[0][CHAN_SAMPLE_BITS-1]))
    else $error("sample field does not start with lane 3");

  a_ref_two_ticks: assert property (
    (ref_select && ref_edge) ##1 ref_select |-> tick)
    else $error("reference edge did not give two bit ticks");

  a_lane_low_map: assert property (
    tick |=> inbound_lanes[3] == $past(shift_q[0][31]) &&
      inbound_lanes[0] == $past(shift_q[0][7]))
    else $error("channel 1 lane order broken");

  a_sample_shift_in: assert property (
    (capture && out_if.valid) |=>
      samp_q[0][7:0] == $past(out_if.data[7:0]) &&
      samp_q[0][15:8] == $past(samp_q[0][7:0]))
    else $error("lane sample did not take the next group byte");

  a_alarm_on_starve: assert property (
    (load && !out_if.valid) |-> ##2 chan1_alarm_line && chan4_alarm_line)
    else $error("alarm not raised on fifo underrun");

  c_underrun: cover property (load && !out_if.valid);
  c_frame_wrap: cover property (load && grp_q == FRAME_LAST);
  c_ref_mode: cover property (ref_select && ref_edge ##1 tick);
  c_fifo_full: cover property (group_valid && !group_ready);
  c_single_mode: cover property (single_chan_mode && tick);

endmodule : qls_rx_striper

// ==== verification/qls_sink_model.sv ====
// far-side sink model: deserialises lanes and deskew streams, syncs alarms
// assumes a bit divider of 1, so every clk edge carries one lane bit
`timescale 1ns/1ns
module qls_sink_model import qls_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link from the striper
  input wire logic [NUM_LANES-1:0] lanes,
  input wire logic [NUM_CHAN-1:0] skew,
  input wire logic [NUM_CHAN-1:0] alarm,
  // observed windows, lane l byte in bits 8l+7..8l, oldest bit on top
  output logic [NUM_LANES*BYTE_BITS-1:0] lane_win,
  output logic [319:0] skew_win [NUM_CHAN],
  output logic [NUM_CHAN-1:0] alarm_sync
);
  logic [NUM_CHAN-1:0] alarm_meta_q;

  ////////////////////////////////////////////////////////////////////////////
  // status has no timing tie to any clock, so two flops before use
  // reset to alarm: nothing is trusted until the line is seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_meta_q <= '1;
      alarm_sync <= '1;
    end else begin
      alarm_meta_q <= alarm;
      alarm_sync <= alarm_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift windows; first received bit ends up as msb
  always @(posedge clk) begin
    for (int l = 0; l < NUM_LANES; l++) begin
      lane_win[8*l+:8] <= {lane_win[8*l+:7], lanes[l]};
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      skew_win[c] <= {skew_win[c][318:0], skew[c]};
    end
  end
endmodule : qls_sink_model

// ==== verification/testbench.sv ====
// testbench: groups driven into the striper, sink model on the lanes
// assumes a bit divider of 1, so every clk is a bit tick
`timescale 1ns/1ns
module testbench import qls_pkg::*; ;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [127:0] gdata = '0;
  logic gvalid = 1'b0;
  logic [3:0] sig_ok = 4'hf;
  logic single = 1'b0;
  logic rsel = 1'b0;
  logic refck = 1'b0;
  logic [1:0] rc = 2'h0;
  logic gready;
  logic [15:0] lanes;
  logic [3:0] fck, skw, alm, asy;
  logic [127:0] lwin;
  logic [319:0] swin [4];
  int failures = 0;
  int samples_checked = 0;
  int tc [4];
  // every byte edged in ones: no shifted copy among zeros can match
  localparam logic [127:0] SOLO = 128'h81c3_e799_bda5_db8f_f1b7_ed9f_f9cb_d3ab;
  localparam logic [127:0] FEED = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_f001;

  always #25 clk = ~clk;

  // free-running reference, half period 4 clks
  always @(posedge clk) begin
    rc <= rc + 2'h1;
    if (rc == 2'h3) refck <= ~refck;
  end

  qls_rx_striper #(.BIT_DIV_CYC(1)) i_dut (
    .clk(clk), .resetn(resetn), .group_data(gdata),
    .group_valid(gvalid), .group_ready(gready), .chan_signal_ok(sig_ok),
    .single_chan_mode(single), .ref_select(rsel),
    .inbound_frequency_reference(refck), .inbound_lanes(lanes),
    .chan1_forwarded_clock(fck[0]), .chan2_forwarded_clock(fck[1]),
    .chan3_forwarded_clock(fck[2]), .chan4_forwarded_clock(fck[3]),
    .chan1_skew_reference(skw[0]), .chan2_skew_reference(skw[1]),
    .chan3_skew_reference(skw[2]), .chan4_skew_reference(skw[3]),
    .chan1_alarm_line(alm[0]), .chan2_alarm_line(alm[1]),
    .chan3_alarm_line(alm[2]), .chan4_alarm_line(alm[3])
  );

  qls_sink_model i_sink (
    .clk(clk), .resetn(resetn), .lanes(lanes), .skew(skw), .alarm(alm),
    .lane_win(lwin), .skew_win(swin), .alarm_sync(asy)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [319:0] got, input logic [319:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic stop_test;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic count_tog(input int n);
    logic [3:0] p;
    tc = '{default: 0};
    tick(1);
    p = fck;
    repeat (n) begin
      tick(1);
      for (int i = 0; i < 4; i++) if (fck[i] !== p[i]) tc[i]++;
      p = fck;
    end
  endtask : count_tog

  function automatic logic [319:0] exp_frame(input logic [31:0] w);
    return {FRAME_WORD, HDR_WORD, {8{w[31:24]}}, {8{w[23:16]}},
            {8{w[15:8]}}, {8{w[7:0]}}};
  endfunction : exp_frame

  ////////////////////////////////////////////////////////////////////////////
  // one group among zero filler: all sixteen lane bytes seen at once
  task automatic t_lanes;
    int i;
    @(posedge clk);
    gdata <= SOLO;
    gvalid <= 1'b1;
    #1;
    while (gready !== 1'b1) tick(1);
    @(posedge clk);
    gvalid <= 1'b0;
    i = 0;
    while (lwin !== SOLO && i < 64) begin
      tick(1);
      i++;
    end
    chk_vec(lwin, SOLO);
    $display("t_lanes done");
  endtask : t_lanes

  // steady feed: fifo fills, then whole deskew frames per channel
  task automatic t_frame;
    int i;
    @(posedge clk);
    gdata <= FEED;
    gvalid <= 1'b1;
    i = 0;
    tick(1);
    while (gready !== 1'b0 && i < 40) begin
      tick(1);
      i++;
    end
    chk_bit(gready, 1'b0);
    tick(400);
    chk_vec(asy, 4'h0);
    for (int c = 0; c < 4; c++) begin
      i = 0;
      while (swin[c][319:288] !== FRAME_WORD && i < 400) begin
        tick(1);
        i++;
      end
      chk_vec(swin[c], exp_frame(FEED[32*c+:32]));
    end
    count_tog(64);
    for (int c = 0; c < 4; c++) chk_vec(tc[c], 32);
    $display("t_frame done");
  endtask : t_frame

  task automatic t_alarm;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      sig_ok <= ~(4'h1 << c);
      tick(6);
      chk_vec(asy, 4'h1 << c);
      @(posedge clk);
      sig_ok <= 4'hf;
      tick(6);
      chk_vec(asy, 4'h0);
    end
    $display("t_alarm done");
  endtask : t_alarm

  task automatic t_single;
    @(posedge clk);
    single <= 1'b1;
    tick(340);
    for (int c = 1; c < 4; c++) chk_vec(swin[c], '0);
    count_tog(64);
    chk_vec(tc[0], 32);
    for (int c = 1; c < 4; c++) chk_vec(tc[c], 0);
    @(posedge clk);
    single <= 1'b0;
    $display("t_single done");
  endtask : t_single

  // one toggle of each data clock per reference edge
  task automatic t_ref;
    @(posedge clk);
    rsel <= 1'b1;
    tick(32);
    count_tog(64);
    for (int c = 0; c < 4; c++) begin
      chk_bit(tc[c] >= 15 && tc[c] <= 17, 1'b1);
    end
    @(posedge clk);
    rsel <= 1'b0;
    $display("t_ref done");
  endtask : t_ref

  // stop feeding: fifo runs dry, filler raises every alarm
  task automatic t_drain;
    int i;
    @(posedge clk);
    gvalid <= 1'b0;
    i = 0;
    tick(1);
    while (asy !== 4'hf && i < 200) begin
      tick(1);
      i++;
    end
    chk_vec(asy, 4'hf);
    chk_bit(gready, 1'b1);
    $display("t_drain done");
  endtask : t_drain

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    chk_vec(alm, 4'hf);
    chk_vec(lanes, 16'h0);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    chk_vec(alm, 4'hf);
    t_lanes();
    t_frame();
    t_alarm();
    t_single();
    t_ref();
    t_drain();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule : testbench
